// ### core/scl_pkg.sv
// constants and types for the serial configuration load port
// Summary of operation
// - shift data bit on each serial clock rise
// - load strobe rise copies word to latch
// - chip enable low powers down lock detect and monitor, not the latches
// - monitor shows lock, scaled VCO or reference
// - overload rising edge drops receive gain 6dB while the device is active
// - control latch field selects monitor source
// - lock after 3/5 good cycles, lost >25ns
package scl_pkg;
  localparam int WORD_W = 24;
  localparam int CTRL_W = 2;
  localparam int NUM_LATCH = 4;
  // latch indices from the control bits
  localparam logic [1:0] LATCH_CONTROL = 2'h0;
  localparam logic [1:0] LATCH_RCOUNT = 2'h1;
  localparam logic [1:0] LATCH_RXCAL = 2'h2;
  localparam logic [1:0] LATCH_TX = 2'h3;
  // field positions inside the latches
  localparam int MON_SEL_LSB = 4;
  localparam int MON_SEL_W = 3;
  localparam int PWR_DOWN_BIT = 2;
  localparam int LOCK_PREC_BIT = 20;
  // monitor source encodings
  localparam logic [2:0] MON_LOW = 3'h0;
  localparam logic [2:0] MON_LOCK = 3'h1;
  localparam logic [2:0] MON_VCO = 3'h2;
  localparam logic [2:0] MON_REF = 3'h3;
  localparam logic [2:0] MON_HIGH = 3'h4;
  // lock detect thresholds in ns and cycle counts
  localparam logic [7:0] LOCK_SET_NS = 8'h0F;
  localparam logic [7:0] LOCK_CLR_NS = 8'h19;
  localparam logic [2:0] LOCK_CNT_NORMAL = 3'h3;
  localparam logic [2:0] LOCK_CNT_PRECISE = 3'h5;
  localparam int GAIN_DROP_DB = 6;
  // apb byte offsets
  localparam logic [7:0] OFF_LATCH0 = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h10;
  localparam logic [7:0] OFF_IRQ_STATUS = 8'h14;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h18;
  localparam logic [7:0] OFF_CTRL = 8'h1C;
  // interrupt status bit positions
  localparam int IRQ_LOAD = 0;
  localparam int IRQ_OVERLOAD = 1;
  localparam int IRQ_LOCK_CHG = 2;
  localparam int IRQ_W = 3;
  localparam logic [WORD_W-1:0] LATCH_RESET = 24'h000000;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 3'h0;
  typedef enum {LOCK_HUNT, LOCK_HELD} scl_lock_state_type;
endpackage

// ### core/scl_shift_if.sv
// word and load event from the serial shifter to the core
`timescale 1ns/1ps
interface scl_shift_if;
  logic [23:0] word;
  logic load_pulse;
  modport src (output word, output load_pulse);
  modport dst (input word, input load_pulse);
endinterface

// ### core/scl_shifter.sv
// three-wire serial shifter sampled on pclk
`timescale 1ns/1ps
module scl_shifter
  import scl_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic serial_clock_input,
  input wire logic serial_bit_input,
  input wire logic latch_load_strobe,
  scl_shift_if.src sh
);
  logic [2:0] sync1_reg;
  logic [2:0] sync2_reg;
  logic sclk_prev_reg;
  logic le_prev_reg;
  logic [WORD_W-1:0] shift_reg;
  logic load_reg;
  wire sclk_rise = sync2_reg[0] & ~sclk_prev_reg;
  wire le_rise = sync2_reg[2] & ~le_prev_reg;

  // two-stage synchronisers for clock, data and strobe
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      sync1_reg <= 3'h0;
      sync2_reg <= 3'h0;
      sclk_prev_reg <= 1'b0;
      le_prev_reg <= 1'b0;
    end
    else
    begin
      sync1_reg <= {latch_load_strobe, serial_bit_input, serial_clock_input};
      sync2_reg <= sync1_reg;
      sclk_prev_reg <= sync2_reg[0];
      le_prev_reg <= sync2_reg[2];
    end

  // shift msb first, control bits end up lowest
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      shift_reg <= LATCH_RESET;
    else if (sclk_rise)
      shift_reg <= {shift_reg[WORD_W-2:0], sync2_reg[1]};

  // one-cycle load event on strobe rise
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      load_reg <= 1'b0;
    else
      load_reg <= le_rise;

  assign sh.word = shift_reg;
  assign sh.load_pulse = load_reg;
endmodule

// ### core/scl_config_port.sv
// serial configuration load port with apb status and control
`timescale 1ns/1ps
module scl_config_port
  import scl_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic serial_clock_input,
  input wire logic serial_bit_input,
  input wire logic latch_load_strobe,
  input wire logic chip_enable,
  input wire logic overload_gain_drop_pin,
  input wire logic vco_scaled_clock,
  input wire logic ref_scaled_clock,
  input wire logic pfd_cycle_pulse,
  input wire logic [7:0] phase_error_ns,
  output logic device_active,
  output logic rx_gain_drop,
  output logic lock_detect,
  output logic monitor_select_output,
  output logic irq
);
  import scl_pkg::*;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  scl_shift_if sh ();
  logic [WORD_W-1:0] latch_reg [NUM_LATCH];
  logic [3:0] pin_s1_reg;
  logic [3:0] pin_s2_reg;
  logic ovf_prev_reg;
  logic lock_reg;
  logic [2:0] good_cnt_reg;
  scl_lock_state_type lock_state_reg;
  logic [IRQ_W-1:0] irq_status_reg;
  logic [IRQ_W-1:0] irq_mask_reg;
  logic ctrl_gain_clear_reg;
  logic gain_drop_reg;
  logic active_reg;
  logic mon_reg;
  logic irq_reg;
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;

  // serial front end
  scl_shifter u_shifter (
    .pclk(pclk),
    .presetn(presetn),
    .serial_clock_input(serial_clock_input),
    .serial_bit_input(serial_bit_input),
    .latch_load_strobe(latch_load_strobe),
    .sh(sh)
  );

  // decoded configuration fields
  wire [1:0] dest = sh.word[CTRL_W-1:0];
  wire [MON_SEL_W-1:0] mon_sel = latch_reg[LATCH_CONTROL][MON_SEL_LSB +: MON_SEL_W];
  wire pwr_down_bit = latch_reg[LATCH_CONTROL][PWR_DOWN_BIT];
  wire precise = latch_reg[LATCH_RCOUNT][LOCK_PREC_BIT];
  wire [2:0] lock_need = precise ? LOCK_CNT_PRECISE : LOCK_CNT_NORMAL;
  wire ce_s = pin_s2_reg[0];
  wire ovf_s = pin_s2_reg[1];
  wire vco_s = pin_s2_reg[2];
  wire ref_s = pin_s2_reg[3];
  wire ovf_rise = ovf_s & ~ovf_prev_reg;
  wire err_bad = phase_error_ns > LOCK_CLR_NS;
  wire err_good = phase_error_ns < LOCK_SET_NS;

  // apb decode
  wire apb_done = psel & penable & pready_reg;
  wire apb_wr = apb_done & pwrite;
  wire apb_access = psel & penable & ~pready_reg;
  wire is_latch = (paddr[7:4] == OFF_LATCH0[7:4]) & (paddr[1:0] == 2'h0);
  wire mapped = is_latch | hit(paddr, OFF_STATUS) | hit(paddr, OFF_IRQ_STATUS)
    | hit(paddr, OFF_IRQ_MASK) | hit(paddr, OFF_CTRL);
  wire [IRQ_W-1:0] w1c = (apb_wr & hit(paddr, OFF_IRQ_STATUS)) ? pwdata[IRQ_W-1:0] : 3'h0;
  wire lock_next_up = lock_state_reg == LOCK_HUNT && pfd_cycle_pulse && err_good
    && (good_cnt_reg + 3'h1 >= lock_need);
  wire lock_next_dn = lock_state_reg == LOCK_HELD && pfd_cycle_pulse && err_bad;
  wire [IRQ_W-1:0] events = {lock_next_up | lock_next_dn, ovf_rise, sh.load_pulse};

  // read data selection
  logic [31:0] rd_mux;
  always_comb
  begin
    rd_mux = 32'h0;
    if (is_latch)
      rd_mux = {8'h0, latch_reg[paddr[3:2]]};
    else if (hit(paddr, OFF_STATUS))
      rd_mux = {27'h0, mon_reg, gain_drop_reg, lock_reg, active_reg, ce_s};
    else if (hit(paddr, OFF_IRQ_STATUS))
      rd_mux = {29'h0, irq_status_reg};
    else if (hit(paddr, OFF_IRQ_MASK))
      rd_mux = {29'h0, irq_mask_reg};
    else if (hit(paddr, OFF_CTRL))
      rd_mux = {31'h0, ctrl_gain_clear_reg};
  end

  // synchronisers for pins from outside the clock domain
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      pin_s1_reg <= 4'h0;
      pin_s2_reg <= 4'h0;
      ovf_prev_reg <= 1'b0;
    end
    else
    begin
      pin_s1_reg <= {ref_scaled_clock, vco_scaled_clock, overload_gain_drop_pin, chip_enable};
      pin_s2_reg <= pin_s1_reg;
      ovf_prev_reg <= ovf_s;
    end

  // four latches, written only on a completed load
  genvar gi;
  generate
    for (gi = 0; gi < NUM_LATCH; gi++)
    begin : g_latch
      always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
          latch_reg[gi] <= LATCH_RESET;
        else if (sh.load_pulse && dest == 2'(gi))
          latch_reg[gi] <= sh.word;
    end
  endgenerate

  // device enable from pin and power-down bit
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      active_reg <= 1'b0;
    else
      active_reg <= ce_s & ~pwr_down_bit;

  // gain drop on overload rise, cleared by rx latch load or software
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      gain_drop_reg <= 1'b0;
    else if (ovf_rise && active_reg)
      gain_drop_reg <= 1'b1;
    else if ((sh.load_pulse && dest == LATCH_RXCAL) || ctrl_gain_clear_reg)
      gain_drop_reg <= 1'b0;

  // digital lock detect
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      lock_state_reg <= LOCK_HUNT;
      good_cnt_reg <= 3'h0;
      lock_reg <= 1'b0;
    end
    else if (!active_reg)
    begin
      lock_state_reg <= LOCK_HUNT;
      good_cnt_reg <= 3'h0;
      lock_reg <= 1'b0;
    end
    else if (pfd_cycle_pulse)
      case (lock_state_reg)
        LOCK_HUNT:
          if (lock_next_up)
          begin
            lock_state_reg <= LOCK_HELD;
            lock_reg <= 1'b1;
            good_cnt_reg <= 3'h0;
          end
          else
            good_cnt_reg <= err_good ? good_cnt_reg + 3'h1 : 3'h0;
        LOCK_HELD:
          if (err_bad)
          begin
            lock_state_reg <= LOCK_HUNT;
            lock_reg <= 1'b0;
          end
        default:
          lock_state_reg <= LOCK_HUNT;
      endcase

  // monitor multiplexer
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      mon_reg <= 1'b0;
    else if (!active_reg)
      mon_reg <= 1'b0;
    else
      case (mon_sel)
        MON_LOCK: mon_reg <= lock_reg;
        MON_VCO: mon_reg <= vco_s;
        MON_REF: mon_reg <= ref_s;
        MON_HIGH: mon_reg <= 1'b1;
        default: mon_reg <= 1'b0;
      endcase

  // sticky interrupt status, set wins over write-one clear
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      irq_status_reg <= 3'h0;
      irq_reg <= 1'b0;
    end
    else
    begin
      irq_status_reg <= (irq_status_reg & ~w1c) | events;
      irq_reg <= |(irq_status_reg & irq_mask_reg);
    end

  // apb slave: one wait state, writes at the completing edge
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h0;
      irq_mask_reg <= IRQ_MASK_RESET;
      ctrl_gain_clear_reg <= 1'b0;
    end
    else
    begin
      pready_reg <= apb_access;
      pslverr_reg <= apb_access & (~mapped | (pwrite & is_latch));
      prdata_reg <= (apb_access && !pwrite) ? rd_mux : 32'h0;
      ctrl_gain_clear_reg <= 1'b0; // self-clearing strobe
      if (apb_wr && hit(paddr, OFF_IRQ_MASK))
        irq_mask_reg <= pwdata[IRQ_W-1:0];
      if (apb_wr && hit(paddr, OFF_CTRL))
        ctrl_gain_clear_reg <= pwdata[0];
    end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign device_active = active_reg;
  assign rx_gain_drop = gain_drop_reg;
  assign lock_detect = lock_reg;
  assign monitor_select_output = mon_reg;
  assign irq = irq_reg;
endmodule

// ### dv/scl_host_model.sv
// host model driving three-wire serial words into the port
`timescale 1ns/1ps
module scl_host_model
(
  input wire logic pclk,
  output logic serial_clock_input,
  output logic serial_bit_input,
  output logic latch_load_strobe
);
  // lines start low, clock stands still between frames
  initial
  begin
    serial_clock_input = 1'b0;
    serial_bit_input = 1'b0;
    latch_load_strobe = 1'b0;
  end
  // shift one word msb first, h pclk per half period, then maybe load
  task automatic send(input logic [23:0] w, input int h, input logic ld);
    for (int i = 23; i >= 0; i--)
    begin
      serial_bit_input <= w[i];
      repeat (h) @(posedge pclk);
      serial_clock_input <= 1'b1;
      repeat (h) @(posedge pclk);
      serial_clock_input <= 1'b0;
    end
    repeat (h) @(posedge pclk);
    serial_bit_input <= ~serial_bit_input; // no stale bit after the frame
    if (ld)
    begin
      latch_load_strobe <= 1'b1;
      repeat (h) @(posedge pclk);
      latch_load_strobe <= 1'b0;
    end
  endtask
endmodule

// ### dv/scl_config_port_monitor.sv
// pin and bus assertions for the configuration port
`timescale 1ns/1ps
module scl_config_port_monitor
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic chip_enable,
  input wire logic overload_gain_drop_pin,
  input wire logic pfd_cycle_pulse,
  input wire logic [7:0] phase_error_ns,
  input wire logic device_active,
  input wire logic rx_gain_drop,
  input wire logic lock_detect,
  input wire logic monitor_select_output
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // bus phases
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence access_s;
    psel && penable && !pready;
  endsequence
  // bus timing and refusals
  wait_state_a: assert property (setup_s |=> !pready ##1 pready)
    else $error("wait state wrong");
  idle_data_a: assert property (!pready |-> prdata == 32'h0)
    else $error("data outside answer");
  bad_addr_a: assert property (access_s ##0 (paddr > 8'h1C) |=> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  latch_write_a: assert property (access_s ##0 (pwrite && paddr < 8'h10) |=> pslverr)
    else $error("latch write not refused");
  // pin behaviour
  gain_drop_a: assert property (
    $rose(overload_gain_drop_pin) && device_active |-> ##[1:6] rx_gain_drop)
    else $error("overload ignored");
  ce_off_a: assert property (!chip_enable [*4] |=> !device_active)
    else $error("active while disabled");
  idle_out_a: assert property (
    !device_active [*3] |-> !lock_detect && !monitor_select_output)
    else $error("outputs live while down");
  lock_loss_a: assert property (
    pfd_cycle_pulse && phase_error_ns > 8'h19 |-> ##[1:3] !lock_detect)
    else $error("lock kept after large error");
endmodule
bind scl_config_port scl_config_port_monitor i_mon (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .prdata, .pready, .pslverr, .chip_enable, .overload_gain_drop_pin,
  .pfd_cycle_pulse, .phase_error_ns, .device_active, .rx_gain_drop, .lock_detect,
  .monitor_select_output);

// ### dv/test_scl_config_port.sv
// self-checking bench for the serial configuration load port
`timescale 1ns/1ps
module test_scl_config_port;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, chip_enable;
  logic serial_clock_input, serial_bit_input, latch_load_strobe, overload_gain_drop_pin;
  logic pfd_cycle_pulse, device_active, rx_gain_drop, lock_detect, monitor_select_output;
  logic vco_scaled_clock, ref_scaled_clock, e_mon;
  logic [7:0] paddr, phase_error_ns;
  logic [31:0] pwdata, prdata;
  logic [23:0] w;
  logic [33:0] e_now;
  logic [33:0] exp_q[$];
  int n_fail = 0;
  int checked = 0;
  scl_config_port i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .serial_clock_input, .serial_bit_input, .latch_load_strobe,
    .chip_enable, .overload_gain_drop_pin, .vco_scaled_clock, .ref_scaled_clock,
    .pfd_cycle_pulse, .phase_error_ns, .device_active, .rx_gain_drop, .lock_detect,
    .monitor_select_output, .irq);
  scl_host_model i_host (.pclk, .serial_clock_input, .serial_bit_input, .latch_load_strobe);
  // comparisons and closing
  task automatic cmp(input logic [32:0] got, input logic [32:0] exp);
    checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED at %0t: bus answer", $time);
    end
  endtask
  task automatic chk(input logic got, input logic exp);
    checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED at %0t: pin level", $time);
    end
  endtask
  task automatic stop_test();
    if (exp_q.size() != 0)
      n_fail++;
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // one apb transfer, expected {error, data} queued for the watcher
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
    input logic [32:0] e);
    exp_q.push_back({wr, e});
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // one comparison cycle with the given phase error
  task automatic pulse(input logic [7:0] e);
    pfd_cycle_pulse <= 1'b1;
    phase_error_ns <= e;
    @(posedge pclk);
    pfd_cycle_pulse <= 1'b0;
    repeat (4) @(posedge pclk);
  endtask
  // clock and watchdog
  initial
  begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  initial
  begin
    #800000;
    n_fail++;
    stop_test();
  end
  // watcher pairs each answer with the oldest expectation
  always @(posedge pclk)
    if (pready === 1'b1 && exp_q.size() > 0)
    begin
      e_now = exp_q.pop_front();
      cmp({pslverr, e_now[33] ? 32'h0 : prdata}, e_now[32:0]);
    end
  // stimulus
  initial
  begin
    {psel, penable, pwrite, paddr, pwdata, presetn} = '0;
    {overload_gain_drop_pin, pfd_cycle_pulse, phase_error_ns} = '0;
    chip_enable = 1'b1;
    {vco_scaled_clock, ref_scaled_clock} = 2'h2;
    void'($urandom(55657));
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, 8'h18, 0, 33'h0);
    apb(1'b0, 8'h20, 0, 33'h1_0000_0000);
    apb(1'b1, 8'h04, 32'h1, 33'h1_0000_0000);
    $display("registers done");
    for (int i = 0; i < 4; i++)
    begin
      w = {22'($urandom()), 2'(i)};
      i_host.send(w, 4, 1'b0);
      repeat (8) @(posedge pclk);
      apb(1'b0, 8'(4 * i), 0, 33'h0);
      i_host.send(w, 4, 1'b1);
      repeat (4) @(posedge pclk);
      apb(1'b0, 8'(4 * i), 0, {9'h0, w});
    end
    apb(1'b0, 8'h14, 0, 33'h1);
    apb(1'b1, 8'h14, 32'h7, 33'h0);
    apb(1'b0, 8'h14, 0, 33'h0);
    $display("latches done");
    for (int m = 0; m < 8; m++)
    begin
      {vco_scaled_clock, ref_scaled_clock} <= 2'($urandom());
      i_host.send({17'h0, 3'(m), 4'h0}, 4, 1'b1);
      repeat (8) @(posedge pclk);
      e_mon = (m == 2) ? vco_scaled_clock : (m == 3) ? ref_scaled_clock : (m == 4);
      chk(monitor_select_output, e_mon);
    end
    i_host.send(24'h000044, 4, 1'b1);
    repeat (8) @(posedge pclk);
    chk(device_active, 1'b0);
    chk(monitor_select_output, 1'b0);
    i_host.send(24'h000040, 4, 1'b1);
    repeat (8) @(posedge pclk);
    chk(device_active, 1'b1);
    chip_enable <= 1'b0;
    repeat (8) @(posedge pclk);
    chk(device_active, 1'b0);
    chip_enable <= 1'b1;
    $display("power done");
    i_host.send(24'h000010, 4, 1'b1);
    for (int p = 0; p < 2; p++)
    begin
      i_host.send({3'h0, 1'(p), 18'h0, 2'h1}, 4, 1'b1);
      for (int k = 0; k < 3 + 2 * p; k++)
      begin
        chk(lock_detect, 1'b0);
        pulse(8'($urandom() % 15));
      end
      chk(lock_detect, 1'b1);
      chk(monitor_select_output, 1'b1);
      pulse(8'h19);
      chk(lock_detect, 1'b1);
      pulse(8'h1A);
      chk(lock_detect, 1'b0);
    end
    $display("lock done");
    apb(1'b1, 8'h14, 32'h7, 33'h0);
    apb(1'b1, 8'h18, 32'h2, 33'h0);
    apb(1'b0, 8'h18, 0, 33'h2);
    overload_gain_drop_pin <= 1'b1;
    repeat (8) @(posedge pclk);
    chk(rx_gain_drop, 1'b1);
    chk(irq, 1'b1);
    apb(1'b0, 8'h10, 0, 33'h0B);
    apb(1'b1, 8'h14, 32'h2, 33'h0);
    repeat (2) @(posedge pclk);
    chk(irq, 1'b0);
    overload_gain_drop_pin <= 1'b0;
    apb(1'b1, 8'h1C, 32'h1, 33'h0);
    repeat (2) @(posedge pclk);
    chk(rx_gain_drop, 1'b0);
    $display("overload done");
    stop_test();
  end
endmodule
